// ===== bench/tb.sv
// Self-checking bench for the trace count and stage1 sequencer block
`timescale 1ns/1ns
module tb;
  import trace_seq_pkg::*;
  // ----------------------------------------------------------------
  // Clock, stimulus and design
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {IDX_STAT, 2'b00};
  localparam logic [7:0] A_CNT = {IDX_COUNT, 2'b00};
  localparam logic [7:0] A_WIN = {IDX_WIN, 2'b00};
  logic clk_i;
  logic rst_i = 1'b1;
  logic por_rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [DATA_W-1:0] wb_dat_i = 32'h0000_0000;
  logic [MATCH_N-1:0] match_i = 4'h0;
  logic trace_half_wr_i = 1'b0;
  logic [DATA_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic armed_o;
  logic [1:0] seq_state_o;
  logic trigger_o;
  logic [DATA_W-1:0] rd;
  int n_fail = 0;
  int cmp_count = 0;

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  trace_count_state1_sequencer #(.ADR_W(8)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .por_rst_i(por_rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .match_i(match_i),
    .trace_half_wr_i(trace_half_wr_i), .armed_o(armed_o),
    .seq_state_o(seq_state_o), .trigger_o(trigger_o)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One classic cycle; the answer is awaited under a bound
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      $display("ERROR bus ack expected 1 seen %b", wb_ack_o);
      wrap_up();
    end else begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rd_chk

  task automatic halves(input int n);
    repeat (n) begin
      @(posedge clk_i);
      trace_half_wr_i <= 1'b1;
    end
    @(posedge clk_i);
    trace_half_wr_i <= 1'b0;
  endtask : halves

  task automatic do_reset(input logic por);
    @(posedge clk_i);
    rst_i <= 1'b1;
    por_rst_i <= por;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    por_rst_i <= 1'b0;
  endtask : do_reset

  function automatic logic [1:0] ch_dest(input logic [3:0] c, input int ch);
    case (c)
      4'h0, 4'h1, 4'h2: return 2'(c + 4'h1);
      4'h3, 4'h4, 4'h5: return (ch == 2) ? 2'(c - 4'h2) : 2'h0;
      4'h6: return (ch == 0) ? 2'h1 : (ch == 1) ? 2'h2 : 2'h0;
      4'h7: return (ch == 0) ? 2'h3 : (ch == 1) ? 2'h2 : 2'h0;
      4'h8: return (ch == 0) ? 2'h1 : (ch == 2) ? 2'h2 : 2'h0;
      4'h9: return (ch == 0) ? 2'h3 : (ch == 2) ? 2'h2 : 2'h0;
      4'hA: return (ch == 1) ? 2'h1 : (ch == 3) ? 2'h2 : 2'h0;
      4'hB: return (ch == 1) ? 2'h3 : (ch == 3) ? 2'h2 : 2'h0;
      4'hC: return (ch < 3) ? 2'h1 : 2'h0;
      default: return 2'h0;
    endcase
  endfunction : ch_dest

  // Ignored channels never block; a final exit beats any lower channel
  function automatic logic [1:0] exp_state(input logic [3:0] c, input logic [3:0] m);
    logic [1:0] r;
    logic [1:0] d;
    r = 2'h0;
    for (int ch = 3; ch >= 0; ch--) begin
      d = ch_dest(c, ch);
      if (m[ch] && d != 2'h0 && r != 2'h3) begin
        r = d;
      end
    end
    return r;
  endfunction : exp_state

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_chk("count after por", A_CNT, 32'h0000_0000);
    rd_chk("status after por", A_STAT, 32'h0000_0000);
    rd_chk("stage1 code after por", A_WIN, 32'h0000_0000);
    rd_chk("unmapped read", 8'h04, 32'h0000_0000);
    rd_chk("misaligned read", 8'h9D, 32'h0000_0000);
    $display("Test regs done");
  endtask : t_regs

  task automatic t_count();
    wr(A_CTRL, 32'h0000_0080);
    halves(5);
    rd_chk("count five halves", A_CNT, 32'h0000_0005);
    rd_chk("count reread", A_CNT, 32'h0000_0005);
    wr(A_CNT, 32'h0000_0055);
    rd_chk("count after write", A_CNT, 32'h0000_0005);
    do_reset(1'b0);
    rd_chk("count after system reset", A_CNT, 32'h0000_0005);
    rd_chk("status after system reset", A_STAT, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0080);
    rd_chk("count after arming", A_CNT, 32'h0000_0000);
    halves(2);
    rd_chk("count one line", A_CNT, 32'h0000_0002);
    do_reset(1'b1);
    rd_chk("count after por", A_CNT, 32'h0000_0000);
    $display("Test count done");
  endtask : t_count

  task automatic t_wrap_end();
    for (int k = 0; k < 2; k++) begin
      wr(A_CTRL, (k == 0) ? 32'h0000_0080 : 32'h0000_0088);
      halves(127);
      rd_chk("count at top", A_CNT, 32'h0000_007F);
      rd_chk("status before wrap", A_STAT, 32'h0000_0040);
      halves(1);
      rd_chk("count at wrap", A_CNT, 32'h0000_0000);
      rd_chk("status at wrap", A_STAT, 32'h0000_00C0);
      halves(1);
      rd_chk("count past wrap", A_CNT, 32'h0000_0001);
    end
    $display("Test wrap end and middle done");
  endtask : t_wrap_end

  task automatic t_wrap_begin();
    wr(A_CTRL, 32'h0000_0084);
    halves(128);
    #1;
    chk("armed after begin wrap", 32'h0000_0000, 32'(armed_o));
    rd_chk("status after begin wrap", A_STAT, 32'h0000_0080);
    halves(2);
    rd_chk("count while disarmed", A_CNT, 32'h0000_0000);
    $display("Test wrap begin done");
  endtask : t_wrap_begin

  task automatic t_window();
    do_reset(1'b1);
    wr(A_WIN, 32'h0000_000B);
    rd_chk("stage1 code", A_WIN, 32'h0000_000B);
    wr(A_CTRL, 32'h0000_0001);
    wr(A_WIN, 32'h0000_0005);
    rd_chk("stage2 code", A_WIN, 32'h0000_0005);
    wr(A_CTRL, 32'h0000_0003);
    wr(A_WIN, 32'h0000_000F);
    rd_chk("match flags", A_WIN, 32'h0000_0000);
    wr(A_CTRL, 32'h0000_0000);
    rd_chk("stage1 code kept", A_WIN, 32'h0000_000B);
    wr(A_CTRL, 32'h0000_0080);
    wr(A_WIN, 32'h0000_0002);
    rd_chk("stage1 write while armed", A_WIN, 32'h0000_000B);
    $display("Test window done");
  endtask : t_window

  task automatic t_decode();
    logic [3:0] pats [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hA, 4'hF};
    logic [1:0] e;
    for (int c = 0; c < 16; c++) begin
      for (int p = 0; p < 8; p++) begin
        wr(A_CTRL, 32'h0000_0000);
        wr(A_WIN, 32'(4'(c)));
        wr(A_CTRL, 32'h0000_0080);
        e = exp_state(4'(c), pats[p]);
        @(posedge clk_i);
        match_i <= pats[p];
        @(posedge clk_i);
        match_i <= 4'h0;
        #1;
        chk("state", 32'(e), 32'(seq_state_o));
        chk("trigger", 32'(e == 2'h3), 32'(trigger_o));
        @(posedge clk_i);
        #1;
        chk("trigger after pulse", 32'h0000_0000, 32'(trigger_o));
      end
    end
    // Flags are latched from the channels whatever the code does
    wr(A_CTRL, 32'h0000_0083);
    @(posedge clk_i);
    match_i <= 4'h4;
    @(posedge clk_i);
    match_i <= 4'h0;
    rd_chk("match flags set", A_WIN, 32'h0000_0004);
    $display("Test decode done");
  endtask : t_decode

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    por_rst_i <= 1'b0;
    t_regs();
    t_count();
    t_wrap_end();
    t_wrap_begin();
    t_window();
    t_decode();
    wrap_up();
  end
endmodule : tb

// ===== hw/state1_decode.sv
// Stage1 next-state decoder with final-first, lowest-channel priority
`timescale 1ns/1ns
module state1_decode
  import trace_seq_pkg::*;
(
  input wire logic [3:0] code_i,
  input wire logic [MATCH_N-1:0] match_i,
  output logic go_o,
  output dest_e dest_o
);

  // ----------------------------------------------------------------
  // Per-channel destination
  // ----------------------------------------------------------------
  function automatic dest_e chan_dest(logic [3:0] code, int ch);
    dest_e d;
    d = DEST_NONE;
    case (code)
      SC_ANY_S2: d = DEST_S2;
      SC_ANY_S3: d = DEST_S3;
      SC_ANY_F: d = DEST_FINAL;
      SC_M2_S2: d = (ch == 2) ? DEST_S2 : DEST_NONE;
      SC_M2_S3: d = (ch == 2) ? DEST_S3 : DEST_NONE;
      SC_M2_F: d = (ch == 2) ? DEST_FINAL : DEST_NONE;
      SC_M0S2_M1S3: d = (ch == 0) ? DEST_S2 : (ch == 1) ? DEST_S3 : DEST_NONE;
      SC_M1S3_M0F: d = (ch == 1) ? DEST_S3 : (ch == 0) ? DEST_FINAL : DEST_NONE;
      SC_M0S2_M2S3: d = (ch == 0) ? DEST_S2 : (ch == 2) ? DEST_S3 : DEST_NONE;
      SC_M2S3_M0F: d = (ch == 2) ? DEST_S3 : (ch == 0) ? DEST_FINAL : DEST_NONE;
      SC_M1S2_M3S3: d = (ch == 1) ? DEST_S2 : (ch == 3) ? DEST_S3 : DEST_NONE;
      SC_M3S3_M1F: d = (ch == 3) ? DEST_S3 : (ch == 1) ? DEST_FINAL : DEST_NONE;
      SC_M012_S2: d = (ch != 3) ? DEST_S2 : DEST_NONE;
      default: d = DEST_NONE;
    endcase
    return d;
  endfunction : chan_dest

  // ----------------------------------------------------------------
  // Priority pick
  // ----------------------------------------------------------------
  // Scan from the top so the lowest channel overwrites; a final hit is kept apart
  always_comb begin
    dest_e d;
    logic fin;
    logic any;
    dest_e pick;
    d = DEST_NONE;
    fin = 1'b0;
    any = 1'b0;
    pick = DEST_NONE;
    for (int ch = MATCH_N - 1; ch >= 0; ch--) begin
      d = chan_dest(code_i, ch);
      if (match_i[ch] && d == DEST_FINAL) begin
        fin = 1'b1;
      end
      if (match_i[ch] && d != DEST_NONE) begin
        any = 1'b1;
        pick = d;
      end
    end
    go_o = any;
    dest_o = fin ? DEST_FINAL : pick;
  end

endmodule : state1_decode

// ===== hw/trace_count_state1_sequencer.sv
// Trace line count, shared state-control window and stage1 sequencer
// Contract
// - Seven-bit count of valid trace lines
// - Wrap sets full; end/mid modes keep counting
// - Arming write clears the count
// - Of the two resets, only power-on reset clears the count
// - Trace buffer reads leave count untouched
// - Count register readable always, writes ignored
// - Count steps in half lines
// - Full at zero; begin mode disarms
// - Full with nonzero count means overwritten
// - Select field picks one of four window registers
// - Stage1 code readable at 00, writable disarmed
// - Code bits 3..0 steer State1 exits
// - Codes 0-2: any match to S2/S3/final
// - Codes 3-5: channel 2 only
// - Codes 6-7: channels 0 and 1
// - Codes 8-9: channels 0 and 2
// - Codes 10-11: channels 1 and 3
// - Code 12: channels 0-2 to State2
// - Codes 13-15 cause no transition
// - Lowest channel wins simultaneous matches
// - Final destination beats all others
// - Alignment 01 is begin alignment
`timescale 1ns/1ns
module trace_count_state1_sequencer
  import trace_seq_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [MATCH_N-1:0] match_i,
  input wire logic trace_half_wr_i,
  output logic armed_o,
  output logic [1:0] seq_state_o,
  output logic trigger_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADR_W < 8) begin : g_adr_chk
    $error("ADR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic armed;
    logic [1:0] sel;
    logic [1:0] align;
    logic [3:0] code1;
    logic [3:0] code2;
    logic [3:0] code3;
    logic [MATCH_N-1:0] mflag;
    seq_state_e seq;
    logic trig;
    logic [CNT_W-1:0] count;
    logic full;
  } state_s;

  localparam state_s ST_POR = '{
    ack: 1'b0,
    rdata: '0,
    armed: 1'b0,
    sel: SEL_RST,
    align: ALIGN_RST,
    code1: CODE_RST,
    code2: CODE_RST,
    code3: CODE_RST,
    mflag: '0,
    seq: SEQ_STATE1,
    trig: 1'b0,
    count: COUNT_RST,
    full: 1'b0
  };

  state_s state_reg;
  state_s state_next;

  logic dec_go;
  dest_e dec_dest;
  logic req;
  logic take_wr;
  logic ctrl_wr;
  logic win_wr;
  logic arm_wr;
  logic adr_ok;
  logic [5:0] idx;

  // ----------------------------------------------------------------
  // Stage1 decoder
  // ----------------------------------------------------------------
  state1_decode u_dec (
    .code_i(state_reg.code1),
    .match_i(match_i),
    .go_o(dec_go),
    .dest_o(dec_dest)
  );

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] rd_word(logic [5:0] ix, logic ok, state_s s);
    logic [DATA_W-1:0] w;
    w = '0;
    if (ok) begin
      case (ix)
        IDX_COUNT: w[CNT_W-1:0] = s.count;
        IDX_WIN: begin
          case (s.sel)
            WIN_S1: w[CODE_LSB +: 4] = s.code1;
            WIN_S2: w[CODE_LSB +: 4] = s.code2;
            WIN_S3: w[CODE_LSB +: 4] = s.code3;
            default: w[MATCH_N-1:0] = s.mflag;
          endcase
        end
        IDX_CTRL: begin
          w[CTRL_ARM_BIT] = s.armed;
          w[CTRL_ALIGN_LSB +: 2] = s.align;
          w[CTRL_SEL_LSB +: 2] = s.sel;
        end
        IDX_STAT: begin
          w[STAT_FULL_BIT] = s.full;
          w[STAT_ARMED_BIT] = s.armed;
          w[STAT_SEQ_LSB +: 2] = 2'(s.seq);
        end
        default: w = '0;
      endcase
    end
    return w;
  endfunction : rd_word

  function automatic seq_state_e dest_to_seq(dest_e d, seq_state_e cur);
    seq_state_e r;
    r = cur;
    case (d)
      DEST_S2: r = SEQ_STATE2;
      DEST_S3: r = SEQ_STATE3;
      DEST_FINAL: r = SEQ_FINAL;
      default: r = cur;
    endcase
    return r;
  endfunction : dest_to_seq

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Writes land on the edge where the master sees ack, never earlier
  assign idx = wb_adr_i[7:2];
  assign adr_ok = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i[ADR_W-1:2] == (ADR_W-2)'(idx));
  assign req = wb_cyc_i && wb_stb_i;
  assign take_wr = req && state_reg.ack && wb_we_i && wb_sel_i[0] && adr_ok;
  assign ctrl_wr = take_wr && (idx == IDX_CTRL);
  assign win_wr = take_wr && (idx == IDX_WIN);
  assign arm_wr = ctrl_wr && wb_dat_i[CTRL_ARM_BIT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.trig = 1'b0;
    state_next.ack = req && !state_reg.ack;
    if (req && !state_reg.ack) begin
      state_next.rdata = rd_word(idx, adr_ok, state_reg);
    end
    // Control: arm, alignment and window select
    if (ctrl_wr) begin
      state_next.armed = wb_dat_i[CTRL_ARM_BIT];
      state_next.align = wb_dat_i[CTRL_ALIGN_LSB +: 2];
      state_next.sel = wb_dat_i[CTRL_SEL_LSB +: 2];
    end
    // Window writes only while disarmed; match flags stay read-only
    if (win_wr && !state_reg.armed) begin
      case (state_reg.sel)
        WIN_S1: state_next.code1 = wb_dat_i[CODE_LSB +: 4];
        WIN_S2: state_next.code2 = wb_dat_i[CODE_LSB +: 4];
        WIN_S3: state_next.code3 = wb_dat_i[CODE_LSB +: 4];
        default: state_next.code1 = state_reg.code1;
      endcase
    end
    // Trace line tally; buffer reads have no path in here
    if (state_reg.armed && trace_half_wr_i && !arm_wr) begin
      state_next.count = state_reg.count + 7'h01;
      if (state_reg.count == COUNT_MAX) begin
        state_next.full = 1'b1;
        if (state_reg.align == ALIGN_BEGIN) begin
          state_next.armed = 1'b0;
        end
      end
    end
    // Sequencer and match flags, only while armed
    if (state_reg.armed && !arm_wr) begin
      state_next.mflag = state_reg.mflag | match_i;
      if (state_reg.seq == SEQ_STATE1 && dec_go) begin
        state_next.seq = dest_to_seq(dec_dest, state_reg.seq);
        state_next.trig = (dec_dest == DEST_FINAL);
      end
    end
    // Arming restarts the session; it outranks a same-cycle hit
    if (arm_wr) begin
      state_next.count = COUNT_RST;
      state_next.full = 1'b0;
      state_next.mflag = '0;
      state_next.seq = SEQ_STATE1;
    end
    // System reset spares the tally so it can be read afterwards
    if (rst_i) begin
      state_next = ST_POR;
      state_next.count = state_reg.count;
      state_next.full = state_reg.full;
    end
  end

  always_ff @(posedge clk_i) begin
    if (por_rst_i) begin
      state_reg <= ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
  assign armed_o = state_reg.armed;
  assign seq_state_o = 2'(state_reg.seq);
  assign trigger_o = state_reg.trig;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || por_rst_i);

  logic half_go;
  assign half_go = state_reg.armed && trace_half_wr_i && !arm_wr;

  AST_CNT_STEP: assert property (
    half_go |=> state_reg.count == 7'($past(state_reg.count) + 7'h01)
  ) else $error("count did not step by one");

  AST_WRAP_FULL: assert property (
    half_go && state_reg.count == COUNT_MAX && state_reg.align != ALIGN_BEGIN
    |=> state_reg.full && state_reg.armed && state_reg.count == 7'h00
  ) else $error("wrap did not set full or stopped counting");

  AST_BEGIN_END: assert property (
    half_go && state_reg.count == COUNT_MAX && state_reg.align == ALIGN_BEGIN
    |=> !state_reg.armed && state_reg.full ##1 !state_reg.armed
  ) else $error("begin alignment did not end session");

  AST_ARM_CLR: assert property (
    arm_wr |=> state_reg.count == 7'h00 && state_reg.armed && !state_reg.full
  ) else $error("arming did not clear count");

  AST_RST_KEEP: assert property (
    @(posedge clk_i) disable iff (por_rst_i)
    rst_i |=> $stable(state_reg.count) && !state_reg.armed
  ) else $error("system reset altered count");

  AST_RO_CNT: assert property (
    take_wr && idx == IDX_COUNT && !half_go |=> $stable(state_reg.count)
  ) else $error("count changed by a write");

  AST_S1_LOCK: assert property (
    win_wr && state_reg.armed |=> $stable(state_reg.code1)
  ) else $error("stage1 code written while armed");

  AST_RD_MFLAG: assert property (
    req && !state_reg.ack && !wb_we_i && adr_ok && idx == IDX_WIN
    && state_reg.sel == WIN_MFLAG
    |=> wb_ack_o && wb_dat_o[MATCH_N-1:0] == $past(state_reg.mflag)
  ) else $error("window did not show match flags");

  AST_ANY_FINAL: assert property (
    state_reg.armed && !arm_wr && state_reg.seq == SEQ_STATE1
    && state_reg.code1 == SC_ANY_F && |match_i
    |=> state_reg.seq == SEQ_FINAL && trigger_o ##1 !trigger_o
  ) else $error("any-match final not taken");

  AST_FINAL_WINS: assert property (
    state_reg.armed && !arm_wr && state_reg.seq == SEQ_STATE1
    && state_reg.code1 == SC_M1S3_M0F && match_i[1] && match_i[0]
    |=> state_reg.seq == SEQ_FINAL
  ) else $error("final destination lost priority");

  AST_LOW_WINS: assert property (
    state_reg.armed && !arm_wr && state_reg.seq == SEQ_STATE1
    && state_reg.code1 == SC_M1S2_M3S3 && match_i[1] && match_i[3]
    |=> state_reg.seq == SEQ_STATE2
  ) else $error("lower channel lost priority");

  AST_RESV: assert property (
    state_reg.seq == SEQ_STATE1 && state_reg.code1 > SC_M012_S2 && !arm_wr
    |=> state_reg.seq == SEQ_STATE1 && !trigger_o
  ) else $error("reserved code moved the sequencer");

  AST_ACK_ONE: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack held longer than one cycle");

  // Only a half line write or an arming write may move the tally
  AST_CNT_HOLD: assert property (
    !half_go && !arm_wr |=> $stable(state_reg.count)
  ) else $error("count moved without a half line write");

  AST_RD_CNT: assert property (
    req && !state_reg.ack && !wb_we_i && adr_ok && idx == IDX_COUNT
    |=> wb_dat_o == DATA_W'($past(state_reg.count))
  ) else $error("count read returned a wrong value");

  AST_RD_S1: assert property (
    req && !state_reg.ack && !wb_we_i && adr_ok && idx == IDX_WIN
    && state_reg.sel == WIN_S1
    |=> wb_dat_o == DATA_W'($past(state_reg.code1))
  ) else $error("window did not show the stage1 code");

  // Once overwriting starts the flag must survive further half writes
  AST_FULL_STAYS: assert property (
    state_reg.full && !arm_wr |=> state_reg.full
  ) else $error("full flag dropped without arming");

  AST_TRIG_S1: assert property (
    trigger_o |-> $past(state_reg.seq) == SEQ_STATE1 && state_reg.seq == SEQ_FINAL
  ) else $error("trigger pulsed without a State1 exit to final");

  COV_ARM: cover property (arm_wr ##1 state_reg.armed);
  COV_WRAP: cover property (half_go && state_reg.count == COUNT_MAX);
  COV_FINAL: cover property (trigger_o);
  COV_MFLAG_RD: cover property (req && state_reg.ack && idx == IDX_WIN
    && state_reg.sel == WIN_MFLAG);
  COV_BEGIN_END: cover property (half_go && state_reg.count == COUNT_MAX
    && state_reg.align == ALIGN_BEGIN);

endmodule : trace_count_state1_sequencer

// ===== inc/trace_seq_pkg.sv
// Shared constants and types for the trace count and stage1 sequencer block
package trace_seq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 7;
  localparam int MATCH_N = 4;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL = 6'h20;
  localparam logic [5:0] IDX_STAT = 6'h21;
  localparam logic [5:0] IDX_COUNT = 6'h26;
  localparam logic [5:0] IDX_WIN = 6'h27;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ARM_BIT = 7;
  localparam int CTRL_ALIGN_LSB = 2;
  localparam int CTRL_SEL_LSB = 0;
  localparam int STAT_FULL_BIT = 7;
  localparam int STAT_ARMED_BIT = 6;
  localparam int STAT_SEQ_LSB = 0;
  localparam int CODE_LSB = 0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] WIN_S1 = 2'h0;
  localparam logic [1:0] WIN_S2 = 2'h1;
  localparam logic [1:0] WIN_S3 = 2'h2;
  localparam logic [1:0] WIN_MFLAG = 2'h3;
  localparam logic [1:0] ALIGN_END = 2'h0;
  localparam logic [1:0] ALIGN_BEGIN = 2'h1;
  localparam logic [1:0] ALIGN_MID = 2'h2;
  localparam logic [3:0] SC_ANY_S2 = 4'h0;
  localparam logic [3:0] SC_ANY_S3 = 4'h1;
  localparam logic [3:0] SC_ANY_F = 4'h2;
  localparam logic [3:0] SC_M2_S2 = 4'h3;
  localparam logic [3:0] SC_M2_S3 = 4'h4;
  localparam logic [3:0] SC_M2_F = 4'h5;
  localparam logic [3:0] SC_M0S2_M1S3 = 4'h6;
  localparam logic [3:0] SC_M1S3_M0F = 4'h7;
  localparam logic [3:0] SC_M0S2_M2S3 = 4'h8;
  localparam logic [3:0] SC_M2S3_M0F = 4'h9;
  localparam logic [3:0] SC_M1S2_M3S3 = 4'hA;
  localparam logic [3:0] SC_M3S3_M1F = 4'hB;
  localparam logic [3:0] SC_M012_S2 = 4'hC;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [1:0] ALIGN_RST = 2'h0;
  localparam logic [CNT_W-1:0] COUNT_RST = 7'h00;
  localparam logic [CNT_W-1:0] COUNT_MAX = 7'h7F;

  typedef enum logic [1:0] {SEQ_STATE1, SEQ_STATE2, SEQ_STATE3, SEQ_FINAL} seq_state_e;
  typedef enum logic [1:0] {DEST_NONE, DEST_S2, DEST_S3, DEST_FINAL} dest_e;

endpackage : trace_seq_pkg
